// >>> shared/adc_seq_regs.svh
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// Register byte offsets on the Avalon-MM slave.
`define OFS_CTRL             8'h00
`define OFS_START            8'h04
`define OFS_STATUS           8'h08
`define OFS_MASK             8'h0c
`define OFS_CCF              8'h10
`define OFS_RESULT           8'h14
`define OFS_THRESH           8'h18
`define OFS_DIEN             8'h1c

// Control register fields (converter_control_two).
`define CTRL_POWER_BIT       0
`define CTRL_CONT_BIT        1
`define CTRL_MULTI_BIT       2
`define CTRL_INTERNAL_CONVERSION_CLOCK_BIT        3
`define CTRL_FRZ_LO          4
`define CTRL_FRZ_HI          5

// Freeze behaviour encodings.
`define FRZ_CONTINUE         2'h0
`define FRZ_STOP_NOW         2'h2

// Sequence start register fields (sequence_start_control).
`define START_CHAN_LO        0
`define START_CHAN_HI        3
`define START_CNT_LO         4
`define START_CNT_HI         7
`define START_ABORT_BIT      8

// Status register fields; bits 0 and 1 are sticky, write one to clear.
`define STAT_SEQ_BIT         0
`define STAT_CMP_BIT         1
`define STAT_BUSY_BIT        8
`define STAT_RECOV_BIT       9

// Reset values.
`define CTRL_RESET           8'h00
`define MASK_RESET           2'h0
`define DIEN_RESET           16'h0000
`define THRESH_RESET         12'hfff

// Timing: clock period and stop recovery time, both in nanoseconds.
`define CLK_PERIOD_NS        100
`define STOP_RECOVERY_NS     2000
`define STOP_RECOVERY_CYCLES ((`STOP_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> shared/adc_seq_pkg.sv
`default_nettype none

package adc_seq_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } conv_state_t;

    // Requests to the analog converter core.
    typedef struct packed {
        logic        start;        // One-cycle pulse: sample the channel.
        logic [3:0]  channel;      // Channel to convert.
        logic        power_down;   // Core held in power-down.
        logic        clk_internal; // Core runs on its internal clock.
    } conv_req_t;

    // Answer from the analog converter core.
    typedef struct packed {
        logic        done;         // One-cycle pulse: result valid.
        logic [11:0] result;       // Conversion result.
    } conv_rsp_t;

    // Whole state of the control block.
    typedef struct packed {
        conv_state_t fsm;
        logic [7:0]  ctrl;
        logic [3:0]  start_chan;
        logic [3:0]  chan_count;
        logic [3:0]  cur_chan;
        logic [3:0]  conv_left;
        logic        active;
        logic        aborted;
        logic        span;
        logic        stop_d;
        logic [7:0]  recov_cnt;
        logic [15:0] ccf;
        logic [11:0] result;
        logic [3:0]  result_chan;
        logic [11:0] threshold;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic [15:0] dien;
        logic [15:0] pad_s1;
        logic [15:0] pad_s2;
        logic [15:0] pad_s3;
        logic [15:0] pad_stable;
        logic [15:0] port_data;
        logic        bus_wait;
        logic [31:0] readdata;
        logic        irq;
        conv_req_t   conv_req;
    } ctl_state_t;

endpackage : adc_seq_pkg

`default_nettype wire

// >>> rtl/adc_sequence_mode_control.sv
// Overview of operation
// RULE_01: Software picks single/continuous, one/several channels.
// RULE_02: Stop without internal clock aborts; restart on exit.
// RULE_03: Restart acts as fresh start, clearing flags.
// RULE_04: Internal clock option keeps converting through stop.
// RULE_05: Conversion spanning stop transition updates nothing; the code still sets the sequence flag and steps the channel.
// RULE_06: Recovery interval after stop; no register access. The code loads the recovery count only when the internal clock bit is set.
// RULE_07: Wait mode behaves exactly like run mode.
// RULE_08: Freeze field selects continue, finish, or stop.
// RULE_09: Digital pad buffer gated per channel by enable.
// RULE_10: Reset leaves converter powered down, defaults set.
// RULE_11: Sequence and compare interrupts with local enables.
// RULE_12: Interrupt high while flag and enable both set.
`include "adc_seq_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module adc_sequence_mode_control (
    // Clock and reset.
    input  wire logic                    sys_clk,
    input  wire logic                    srst,
    // Avalon-MM register slave.
    input  wire logic [7:0]              avm_address,
    input  wire logic                    avm_read,
    input  wire logic                    avm_write,
    input  wire logic [31:0]             avm_writedata,
    input  wire logic [3:0]              avm_byteenable,
    output logic      [31:0]             avm_readdata,
    output logic                         avm_waitrequest,
    // Device operating modes.
    input  wire logic                    stop_mode,
    input  wire logic                    freeze_mode,
    // Analog converter core.
    output adc_seq_pkg::conv_req_t       conv_req,
    input  wire adc_seq_pkg::conv_rsp_t  conv_rsp,
    // Input pads and digital port.
    input  wire logic [15:0]             pad_digital_in,
    output logic      [15:0]             port_data,
    // Interrupt request.
    output logic                         irq
);

    // Stop recovery count, sized for the counter it loads.
    localparam logic [7:0] RECOV_CYCLES = 8'(`STOP_RECOVERY_CYCLES);

    // Reset image: converter powered down, bus stalled until a request arrives.
    localparam adc_seq_pkg::ctl_state_t RESET_STATE = '{
        fsm:       adc_seq_pkg::ST_IDLE,
        ctrl:      `CTRL_RESET,
        threshold: `THRESH_RESET,
        mask:      `MASK_RESET,
        dien:      `DIEN_RESET,
        bus_wait:  1'b1,
        conv_req:  '{start: 1'b0, channel: 4'h0, power_down: 1'b1, clk_internal: 1'b0},
        default:   '0
    };

    adc_seq_pkg::ctl_state_t st;       // Registered state.
    adc_seq_pkg::ctl_state_t st_next;  // Next state.
    logic                    halt_w;   // Starting a new conversion is held off.

    // Merges write data into a register under the byte enables.
    function automatic logic [31:0] wr_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : wr_merge

    // Read multiplexer; unmapped offsets read as zero.
    function automatic logic [31:0] read_mux(input adc_seq_pkg::ctl_state_t s, input logic [7:0] addr);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (addr)
            `OFS_CTRL:   v[7:0] = s.ctrl;
            `OFS_START:  v[7:0] = {s.chan_count, s.start_chan};
            `OFS_STATUS: begin
                v[1:0]            = s.status;
                v[`STAT_BUSY_BIT]  = s.active;
                v[`STAT_RECOV_BIT] = (s.recov_cnt != 8'h00);
            end
            `OFS_MASK:   v[1:0] = s.mask;
            `OFS_CCF:    v[15:0] = s.ccf;
            `OFS_RESULT: v[19:0] = {s.result_chan, 4'h0, s.result};
            `OFS_THRESH: v[11:0] = s.threshold;
            `OFS_DIEN:   v[15:0] = s.dien;
            default:     v = 32'h0000_0000;
        endcase
        return v;
    endfunction : read_mux

    // Freeze other than continue, or stop without the internal clock, holds off new conversions.
    assign halt_w = (stop_mode && !st.ctrl[`CTRL_INTERNAL_CONVERSION_CLOCK_BIT]) ||
                    (freeze_mode && st.ctrl[`CTRL_FRZ_HI:`CTRL_FRZ_LO] != `FRZ_CONTINUE); // RULE_08

    // All next-state logic. Bus writes come first so that hardware events later in the
    // process win over a software clear landing in the same cycle.
    always_comb begin
        logic        do_start;
        logic [31:0] merged;
        do_start = 1'b0;
        merged   = 32'h0000_0000;
        st_next  = st;
        st_next.conv_req.start = 1'b0;

        // Pad inputs cross into the clock domain through three stages; a value is accepted
        // only once the second and third agree, so a pad caught mid-change never leaks out.
        st_next.pad_s1 = pad_digital_in;
        st_next.pad_s2 = st.pad_s1;
        st_next.pad_s3 = st.pad_s2;
        if (st.pad_s2 == st.pad_s3) begin
            st_next.pad_stable = st.pad_s3;
        end
        // The analog path is untouched; only the digital copy is gated per channel.
        st_next.port_data = st_next.pad_stable & st.dien; // RULE_09

        // Stop-mode edges. Wait mode is not an input at all: the block runs on as in run mode.
        st_next.stop_d = stop_mode; // RULE_07
        if (stop_mode != st.stop_d && st.fsm == adc_seq_pkg::ST_CONV) begin
            st_next.span = 1'b1; // RULE_05
        end
        if (!stop_mode && st.stop_d) begin
            if (st.ctrl[`CTRL_INTERNAL_CONVERSION_CLOCK_BIT]) begin
                st_next.recov_cnt = RECOV_CYCLES; // RULE_06
            end
            if (st.aborted) begin
                do_start = 1'b1; // RULE_02
            end
        end else if (st.recov_cnt != 8'h00) begin
            st_next.recov_cnt = st.recov_cnt - 8'h01;
        end

        // Bus handshake: one cycle of waitrequest low per request, never during recovery.
        // The next count is tested so that a request seen on the stop exit edge is not
        // acknowledged in the first cycle of recovery.
        if (st.bus_wait && (avm_read || avm_write) && st_next.recov_cnt == 8'h00) begin
            st_next.bus_wait = 1'b0; // RULE_06
            st_next.readdata = read_mux(st, avm_address);
        end else begin
            st_next.bus_wait = 1'b1;
        end

        // Writes take effect at the edge where waitrequest is seen low.
        if (!st.bus_wait && avm_write) begin
            case (avm_address)
                `OFS_CTRL: begin
                    merged       = wr_merge({24'h0, st.ctrl}, avm_writedata, avm_byteenable);
                    st_next.ctrl = merged[7:0]; // RULE_01
                end
                `OFS_START: begin
                    if (avm_byteenable[1] && avm_writedata[`START_ABORT_BIT]) begin
                        // Software abort drops the sequence and any pending restart.
                        st_next.active  = 1'b0;
                        st_next.aborted = 1'b0;
                        st_next.fsm     = adc_seq_pkg::ST_IDLE;
                    end else if (avm_byteenable[0]) begin
                        st_next.start_chan = avm_writedata[`START_CHAN_HI:`START_CHAN_LO];
                        st_next.chan_count = avm_writedata[`START_CNT_HI:`START_CNT_LO];
                        do_start           = 1'b1;
                    end
                end
                `OFS_STATUS: begin
                    if (avm_byteenable[0]) begin
                        st_next.status = st.status & ~avm_writedata[1:0];
                    end
                end
                `OFS_MASK: begin
                    merged       = wr_merge({30'h0, st.mask}, avm_writedata, avm_byteenable);
                    st_next.mask = merged[1:0];
                end
                `OFS_THRESH: begin
                    merged            = wr_merge({20'h0, st.threshold}, avm_writedata, avm_byteenable);
                    st_next.threshold = merged[11:0];
                end
                `OFS_DIEN: begin
                    merged       = wr_merge({16'h0, st.dien}, avm_writedata, avm_byteenable);
                    st_next.dien = merged[15:0]; // RULE_09
                end
                default: begin
                    // Unmapped or read-only offset: the write is acknowledged and dropped.
                end
            endcase
        end

        // A fresh start, from software or after an aborted stop, clears every result flag.
        if (do_start) begin
            st_next.active    = 1'b1; // RULE_03
            st_next.aborted   = 1'b0;
            st_next.fsm       = adc_seq_pkg::ST_IDLE;
            st_next.cur_chan  = st_next.start_chan;
            st_next.conv_left = st.ctrl[`CTRL_MULTI_BIT] ? st_next.chan_count : 4'h0; // RULE_01
            st_next.ccf       = 16'h0000; // RULE_03
            st_next.status    = 2'h0;
        end else if (!st.ctrl[`CTRL_POWER_BIT]) begin
            // Powered down: nothing runs.
            st_next.active = 1'b0; // RULE_10
            st_next.fsm    = adc_seq_pkg::ST_IDLE;
        end else if (stop_mode && !st.ctrl[`CTRL_INTERNAL_CONVERSION_CLOCK_BIT] && st.active) begin
            // Stop without the internal clock kills the sequence; it is replayed on exit.
            st_next.active  = 1'b0; // RULE_02
            st_next.aborted = 1'b1;
            st_next.fsm     = adc_seq_pkg::ST_IDLE;
        end else begin
            case (st.fsm)
                adc_seq_pkg::ST_IDLE: begin
                    if (st.active && !halt_w) begin
                        st_next.fsm            = adc_seq_pkg::ST_CONV;
                        st_next.conv_req.start = 1'b1;
                        st_next.span           = 1'b0;
                    end
                end
                adc_seq_pkg::ST_CONV: begin
                    if (freeze_mode && st.ctrl[`CTRL_FRZ_HI:`CTRL_FRZ_LO] == `FRZ_STOP_NOW) begin
                        // Stop at once; the same channel is sampled again after freeze.
                        st_next.fsm = adc_seq_pkg::ST_IDLE; // RULE_08
                    end else if (conv_rsp.done) begin
                        st_next.fsm = adc_seq_pkg::ST_IDLE;
                        // A result whose sampling crossed a stop edge may be corrupt: drop it.
                        if (!st.span && stop_mode == st.stop_d) begin
                            st_next.result               = conv_rsp.result; // RULE_05
                            st_next.result_chan          = st.cur_chan;
                            st_next.ccf[st.cur_chan]     = 1'b1;
                            if (conv_rsp.result > st.threshold) begin
                                st_next.status[`STAT_CMP_BIT] = 1'b1; // RULE_11
                            end
                        end
                        if (st.conv_left == 4'h0) begin
                            st_next.status[`STAT_SEQ_BIT] = 1'b1; // RULE_11
                            st_next.cur_chan  = st.start_chan;
                            st_next.conv_left = st.ctrl[`CTRL_MULTI_BIT] ? st.chan_count : 4'h0;
                            st_next.active    = st.ctrl[`CTRL_CONT_BIT]; // RULE_01
                        end else begin
                            st_next.cur_chan  = st.cur_chan + 4'h1;
                            st_next.conv_left = st.conv_left - 4'h1;
                        end
                    end
                end
                default: begin
                    st_next.fsm = adc_seq_pkg::ST_IDLE;
                end
            endcase
        end

        // Converter core controls; the internal clock holds through recovery.
        st_next.conv_req.channel      = st_next.cur_chan;
        st_next.conv_req.power_down   = !st_next.ctrl[`CTRL_POWER_BIT]; // RULE_10
        st_next.conv_req.clk_internal = (stop_mode && st.ctrl[`CTRL_INTERNAL_CONVERSION_CLOCK_BIT]) ||
                                        (st_next.recov_cnt != 8'h00); // RULE_04
        // Level interrupt from sticky flags gated by their local enables.
        st_next.irq = |(st.status & st.mask); // RULE_12
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= RESET_STATE; // RULE_10
        end else begin
            st <= st_next;
        end
    end

    // Every output is a field of the state register.
    assign avm_readdata    = st.readdata;
    assign avm_waitrequest = st.bus_wait;
    assign conv_req        = st.conv_req;
    assign port_data       = st.port_data;
    assign irq             = st.irq;

    a_irq_level: assert property (@(posedge sys_clk) disable iff (srst) // RULE_12
        (|(st.status & st.mask)) |=> irq)
        else $error("irq low while an enabled flag is set");
    a_irq_clear: assert property (@(posedge sys_clk) disable iff (srst) // RULE_11
        ((st.status & st.mask) == 2'h0) |=> !irq)
        else $error("irq high with no enabled flag");
    a_recov_stall: assert property (@(posedge sys_clk) disable iff (srst) // RULE_06
        (st.recov_cnt != 8'h00) |-> avm_waitrequest)
        else $error("bus answered during stop recovery");
    a_recov_load: assert property (@(posedge sys_clk) disable iff (srst) // RULE_06
        (!stop_mode && st.stop_d && st.ctrl[`CTRL_INTERNAL_CONVERSION_CLOCK_BIT]) |=> (st.recov_cnt == RECOV_CYCLES))
        else $error("recovery count not loaded on stop exit");
    a_stop_abort: assert property (@(posedge sys_clk) disable iff (srst) // RULE_02
        (stop_mode && !st.ctrl[`CTRL_INTERNAL_CONVERSION_CLOCK_BIT] && st.active && st.ctrl[`CTRL_POWER_BIT] && !avm_write)
        |=> (st.fsm == adc_seq_pkg::ST_IDLE && st.aborted && !st.active))
        else $error("stop did not abort the sequence");
    a_restart_clr: assert property (@(posedge sys_clk) disable iff (srst) // RULE_03
        (!stop_mode && st.stop_d && st.aborted) |=> (st.ccf == 16'h0000 && st.active))
        else $error("restart after stop did not clear flags");
    a_span_drop: assert property (@(posedge sys_clk) disable iff (srst) // RULE_05
        (st.fsm == adc_seq_pkg::ST_CONV && conv_rsp.done && st.span) |=> $stable(st.result))
        else $error("spanning conversion updated the result");
    a_freeze_hold: assert property (@(posedge sys_clk) disable iff (srst) // RULE_08
        conv_req.start |-> !$past(halt_w))
        else $error("conversion started while halted");
    a_pad_gate: assert property (@(posedge sys_clk) disable iff (srst) // RULE_09
        ##1 ((port_data & ~$past(st.dien)) == 16'h0000))
        else $error("digital port not gated by enable");
    a_power_down: assert property (@(posedge sys_clk) disable iff (srst) // RULE_10
        !st.ctrl[`CTRL_POWER_BIT] |=> (st.fsm == adc_seq_pkg::ST_IDLE &&
                                       conv_req.power_down == !st.ctrl[`CTRL_POWER_BIT]))
        else $error("converter running while powered down");

endmodule : adc_sequence_mode_control

`default_nettype wire

// >>> sim/adc_core_model.sv
`timescale 1ns/100ps
`default_nettype none

// Behavioural converter core: answers each start after lat cycles with a
// result built from the channel, so every channel has a known value.
module adc_core_model (
    // Clock and reset.
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    // Requests, latency and answers.
    input  wire adc_seq_pkg::conv_req_t conv_req,
    input  wire logic [7:0]             lat,
    output adc_seq_pkg::conv_rsp_t      conv_rsp
);
    logic [7:0] cnt;  // Cycles left in the running conversion.
    logic       busy; // A conversion is running.
    logic [3:0] chan; // Channel being converted.

    // The result is not held between answers: it toggles so a stale read shows.
    always_ff @(posedge sys_clk) begin
        conv_rsp.done   <= 1'b0;
        conv_rsp.result <= ~conv_rsp.result;
        if (srst || conv_req.power_down) begin
            busy            <= 1'b0;
            conv_rsp.result <= 12'h000;
        end else if (conv_req.start) begin
            busy <= 1'b1;
            cnt  <= lat;
            chan <= conv_req.channel;
        end else if (busy && cnt <= 8'h01) begin
            busy            <= 1'b0;
            conv_rsp.done   <= 1'b1;
            conv_rsp.result <= {chan, 8'h5a};
        end else if (busy) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule : adc_core_model

`default_nettype wire

// >>> sim/tb_adc_sequence_mode_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_regs.svh"

module tb_adc_sequence_mode_control;
    logic                   sys_clk, srst, avm_read, avm_write, avm_waitrequest;
    logic [7:0]             avm_address, lat;
    logic [31:0]            avm_writedata, avm_readdata, q;
    logic [3:0]             avm_byteenable;
    logic                   stop_mode, freeze_mode, irq;
    logic [15:0]            pad_digital_in, port_data;
    adc_seq_pkg::conv_req_t conv_req;
    adc_seq_pkg::conv_rsp_t conv_rsp;
    int                     n_mismatch, check_count, n_starts, s0;

    adc_sequence_mode_control i_dut (.sys_clk(sys_clk), .srst(srst), .avm_address(avm_address),
        .avm_read(avm_read), .avm_write(avm_write), .avm_writedata(avm_writedata),
        .avm_byteenable(avm_byteenable), .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
        .stop_mode(stop_mode), .freeze_mode(freeze_mode), .conv_req(conv_req), .conv_rsp(conv_rsp),
        .pad_digital_in(pad_digital_in), .port_data(port_data), .irq(irq));
    adc_core_model i_core (.sys_clk(sys_clk), .srst(srst), .conv_req(conv_req), .lat(lat),
        .conv_rsp(conv_rsp));

    // Clock at 10 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Start pulses are counted by a single writer to avoid a race with the tests.
    always @(posedge sys_clk) if (conv_req.start === 1'b1) n_starts <= n_starts + 1;

    task automatic summarize();
        $display("counts: %0d checks, %0d mismatches", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cycles

    // One Avalon-MM access; the request stands until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int i;
        @(posedge sys_clk);
        avm_address    <= a;
        avm_write      <= wr;
        avm_read       <= ~wr;
        avm_writedata  <= d;
        avm_byteenable <= be;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (avm_waitrequest !== 1'b0 && i < 200);
        q = avm_readdata;
        if (i >= 200) check(32'h1, 32'h0);
        avm_read  <= 1'b0;
        avm_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
        bus(1'b1, a, d, be);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check(q, exp);
    endtask : rd

    // Bounded waits on the interrupt line and on the core's answer.
    task automatic wait_irq();
        int i;
        for (i = 0; i < 500 && irq !== 1'b1; i++) @(posedge sys_clk);
        check({31'h0, irq}, 32'h1);
    endtask : wait_irq

    task automatic wait_done();
        int i;
        for (i = 0; i < 500 && conv_rsp.done !== 1'b1; i++) @(posedge sys_clk);
        check({31'h0, conv_rsp.done}, 32'h1);
    endtask : wait_done

    task automatic t_reset();
        check({31'h0, conv_req.power_down}, 32'h1);
        rd(`OFS_CTRL, 32'h0);
        rd(`OFS_STATUS, 32'h0);
        rd(`OFS_MASK, 32'h0);
        rd(`OFS_THRESH, 32'hfff);
        rd(`OFS_DIEN, 32'h0);
        rd(`OFS_CCF, 32'h0);
        rd(`OFS_RESULT, 32'h0);
        rd(8'h20, 32'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_single();
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_MASK, 32'h1);
        wr(`OFS_START, 32'h05);
        wait_irq();
        rd(`OFS_CCF, 32'h0020);
        rd(`OFS_RESULT, 32'h0005_055a);
        rd(`OFS_STATUS, 32'h1);
        wr(`OFS_STATUS, 32'h1);
        cycles(2);
        check({31'h0, irq}, 32'h0);
        $display("single test done");
    endtask : t_single

    // Channels 14, 15 and 0 wrap; channels 14 and 15 exceed the threshold.
    task automatic t_multi();
        wr(`OFS_CTRL, 32'h5);
        wr(`OFS_THRESH, 32'h300);
        wr(`OFS_START, 32'h2e);
        wait_irq();
        rd(`OFS_STATUS, 32'h3);
        rd(`OFS_CCF, 32'hc001);
        rd(`OFS_RESULT, 32'h0000_005a);
        wr(`OFS_MASK, 32'h2);
        wr(`OFS_STATUS, 32'h1);
        cycles(2);
        check({31'h0, irq}, 32'h1);
        wr(`OFS_STATUS, 32'h2);
        cycles(2);
        check({31'h0, irq}, 32'h0);
        $display("multi test done");
    endtask : t_multi

    // Stop without the internal clock aborts; exit restarts like a start write.
    task automatic t_stop_abort();
        lat <= 8'd30;
        wr(`OFS_MASK, 32'h1);
        wr(`OFS_THRESH, 32'hfff);
        wr(`OFS_START, 32'h12);
        wait_done();
        cycles(3);
        stop_mode <= 1'b1;
        cycles(10);
        check({31'h0, conv_req.clk_internal}, 32'h0);
        stop_mode <= 1'b0;
        cycles(3);
        rd(`OFS_CCF, 32'h0);
        wait_irq();
        rd(`OFS_CCF, 32'h000c);
        $display("stop abort test done");
    endtask : t_stop_abort

    // With the internal clock the conversion spanning stop entry is discarded.
    task automatic t_stop_internal_conversion_clock();
        wr(`OFS_CTRL, 32'h9);
        wr(`OFS_START, 32'h07);
        cycles(5);
        stop_mode <= 1'b1;
        wait_done();
        cycles(2);
        check({31'h0, conv_req.clk_internal}, 32'h1);
        rd(`OFS_CCF, 32'h0);
        rd(`OFS_RESULT, 32'h0003_035a);
        stop_mode <= 1'b0;
        cycles(`STOP_RECOVERY_CYCLES + 3);
        check({31'h0, conv_req.clk_internal}, 32'h0);
        wr(`OFS_START, 32'h100, 4'h2);
        $display("stop internal clock test done");
    endtask : t_stop_internal_conversion_clock

    // Only freeze code 00 keeps converting while frozen.
    task automatic t_freeze();
        lat <= 8'd5;
        for (int m = 0; m < 4; m++) begin
            wr(`OFS_CTRL, 32'h3 | (32'(m) << 4));
            wr(`OFS_START, 32'h03);
            cycles(10);
            freeze_mode <= 1'b1;
            cycles(20);
            s0 = n_starts;
            cycles(40);
            check({31'h0, n_starts != s0}, {31'h0, m == 0});
            freeze_mode <= 1'b0;
            wr(`OFS_START, 32'h100, 4'h2);
            cycles(5);
        end
        $display("freeze test done");
    endtask : t_freeze

    task automatic t_pads();
        pad_digital_in <= 16'ha5c3;
        wr(`OFS_DIEN, 32'hf0f0);
        cycles(8);
        check({16'h0, port_data}, 32'ha0c0);
        wr(`OFS_DIEN, 32'h00ff, 4'h2);
        cycles(3);
        check({16'h0, port_data}, 32'h00c0);
        rd(`OFS_DIEN, 32'h00f0);
        $display("pad test done");
    endtask : t_pads

    // Main sequence: reset for 16 cycles, then every scenario in turn.
    initial begin
        {srst, avm_read, avm_write, stop_mode, freeze_mode} = 5'h10;
        {avm_address, avm_writedata, avm_byteenable} = '0;
        {pad_digital_in, lat, n_mismatch, check_count} = '0;
        lat = 8'd4;
        cycles(16);
        srst <= 1'b0;
        t_reset();
        t_single();
        t_multi();
        t_stop_abort();
        t_stop_internal_conversion_clock();
        t_freeze();
        t_pads();
        summarize();
    end

    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        cycles(30000);
        n_mismatch++;
        $display("watchdog expired at %0t", $time);
        summarize();
    end
endmodule : tb_adc_sequence_mode_control

`default_nettype wire
